// ===== sbrg_pkg.sv
// Package of constants and types for the serial baud rate generator.
// Function
// RL1 - Divider resets as 8-bit; 16-bit only while wide select is set.
// RL2 - Free-running timer, period from divisor pair, makes the bit clock.
// RL3 - Async divide ratio depends on high-speed, wide select and divisor.
// RL4 - Sync mode ignores high-speed; rate is clock over 4 times (n+1).
// RL5 - Rates apply only when port makes its clock; slave takes none.
// RL6 - Async, both select bits clear: clock over 64 times (n+1).
// RL7 - Async, exactly one select bit set: clock over 16 times (n+1).
// RL8 - Writing either divisor register clears the divider timer at once.
// RL9 - Software never programs a divisor of zero.
// RL10 - Async unless both selects set: three samples, majority vote.
// RL11 - Sync or both selects set: receive input sampled once per bit.
// RL12 - Software picks the nearest integer divisor from the formula.
// RL13 - Software may pick high speed or wide divider to cut error.
// RL14 - Software may reprogram divisor when the system clock changes.
// RL15 - Async, both selects set: clock over 4 times (n+1).
// RL16 - Wide select clear: only the low divisor byte counts.
// RL17 - Sync: clock source set means master from divider, else slave.
package sbrg_pkg;

  // Register offsets on the plain register port.
  localparam logic [2:0] SBRG_OFF_TX_CTRL = 3'h0;
  localparam logic [2:0] SBRG_OFF_RX_CTRL = 3'h1;
  localparam logic [2:0] SBRG_OFF_RATE_CTRL = 3'h2;
  localparam logic [2:0] SBRG_OFF_DIV_HIGH = 3'h3;
  localparam logic [2:0] SBRG_OFF_DIV_LOW = 3'h4;

  // Field positions.
  localparam int SBRG_BIT_CLOCK_SOURCE = 7;
  localparam int SBRG_BIT_SYNC_MODE = 4;
  localparam int SBRG_BIT_HIGH_SPEED = 2;
  localparam int SBRG_BIT_PORT_ENABLE = 7;
  localparam int SBRG_BIT_WIDE_DIVIDER = 3;

  // Reset values.
  localparam logic [7:0] SBRG_RST_TX_CTRL = 8'h02;
  localparam logic [7:0] SBRG_RST_RX_CTRL = 8'h00;
  localparam logic [7:0] SBRG_RST_RATE_CTRL = 8'h40; // Receive idle set.
  localparam logic [7:0] SBRG_RST_DIV = 8'h00;

  // Writable bit masks; read-only and unimplemented bits stay put.
  localparam logic [7:0] SBRG_WMASK_TX_CTRL = 8'hFD;
  localparam logic [7:0] SBRG_WMASK_RX_CTRL = 8'hF9;
  localparam logic [7:0] SBRG_WMASK_RATE_CTRL = 8'hBB;

  // Prescale counts per divider tick.
  localparam logic [5:0] SBRG_PRE_64 = 6'h3F;
  localparam logic [5:0] SBRG_PRE_16 = 6'h0F;
  localparam logic [5:0] SBRG_PRE_4 = 6'h03;

  // Register-port request.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sbrg_req_t;

  // Decoded rate configuration.
  typedef struct packed {
    logic sync_mode;
    logic high_speed;
    logic wide;
    logic clock_source;
    logic enable;
  } sbrg_cfg_t;

  // Divider modes.
  typedef enum logic [1:0] {
    SBRG_DIV64 = 2'b00,
    SBRG_DIV16 = 2'b01,
    SBRG_DIV4 = 2'b10,
    SBRG_STOP = 2'b11
  } sbrg_mode_t;

endpackage

// ===== sbrg_sampler.sv
// Receive-input sampler: three-flop synchroniser plus majority vote.
`timescale 1ns/10ps
`default_nettype none
module sbrg_sampler (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Control.
  input wire logic sample_in,
  input wire logic majority_in,
  input wire logic rx_pin_in,
  // Result.
  output logic rx_bit_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic [2:0] hist_q;
  logic rx_bit_q;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; only s2 and s3 are looked at downstream.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= rx_pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // The level only counts once the second and third flops agree.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      hist_q <= 3'h7;
    end else if (s2_q == s3_q) begin
      hist_q <= {hist_q[1:0], s3_q};
    end
  end

  // Majority vote over three samples, or a single sample.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      rx_bit_q <= 1'b1;
    end else if (sample_in) begin
      if (majority_in) begin
        rx_bit_q <= (hist_q[0] & hist_q[1]) | (hist_q[1] & hist_q[2]) |
                    (hist_q[0] & hist_q[2]); // RL10
      end else begin
        rx_bit_q <= hist_q[0]; // RL11
      end
    end
  end

  assign rx_bit_out = rx_bit_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks: the single sample takes the newest agreed level, and the vote
  // follows the two older samples whenever they agree.
  a_single_sample: assert property (@(posedge sys_clk_in) // RL11
    disable iff (!rstn_in) (sample_in && !majority_in) |=>
      rx_bit_q == $past(hist_q[0]))
    else $error("single sample did not take the newest level");

  a_majority_vote: assert property (@(posedge sys_clk_in) // RL10
    disable iff (!rstn_in) (sample_in && majority_in &&
      hist_q[1] == hist_q[2]) |=> rx_bit_q == $past(hist_q[2]))
    else $error("majority vote lost to a single sample");

endmodule // sbrg_sampler
`default_nettype wire

// ===== sbrg_top.sv
// Baud rate generator top: registers, prescaler, divider timer, sampling.
`timescale 1ns/10ps
`default_nettype none
module sbrg_top (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Register port.
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Serial side.
  input wire logic rx_pin_in,
  output logic bit_tick_out,
  output logic bit_clk_out,
  output logic rx_bit_out,
  output logic master_out
);

  sbrg_pkg::sbrg_req_t req;
  sbrg_pkg::sbrg_cfg_t cfg;
  sbrg_pkg::sbrg_mode_t mode;
  logic [7:0] tx_ctrl_q;
  logic [7:0] rx_ctrl_q;
  logic [7:0] rate_ctrl_q;
  logic [7:0] div_high_q;
  logic [7:0] div_low_q;
  logic [7:0] rdata_q;
  logic [5:0] pre_q;
  logic [5:0] pre_top;
  logic [15:0] cnt_q;
  logic [15:0] divisor;
  logic div_wr;
  logic pre_tick;
  logic tick_q;
  logic bit_clk_q;
  logic master_q;
  logic rx_sample;
  logic wrap;

  // Pick the prescale count for the current configuration.
  function automatic sbrg_pkg::sbrg_mode_t pick_mode(
    input sbrg_pkg::sbrg_cfg_t c);
    if (!c.enable || (c.sync_mode && !c.clock_source)) begin
      pick_mode = sbrg_pkg::SBRG_STOP; // RL5 RL17
    end else if (c.sync_mode) begin
      pick_mode = sbrg_pkg::SBRG_DIV4; // RL4
    end else if (c.high_speed && c.wide) begin
      pick_mode = sbrg_pkg::SBRG_DIV4; // RL15
    end else if (c.high_speed || c.wide) begin
      pick_mode = sbrg_pkg::SBRG_DIV16; // RL7
    end else begin
      pick_mode = sbrg_pkg::SBRG_DIV64; // RL6
    end
  endfunction

  // True on the prescale tick that closes a divider period; the compare
  // is at-or-above so a divisor narrowed mid-count still ends the period.
  function automatic logic period_end(input logic tick,
    input logic [15:0] count, input logic [15:0] top);
    period_end = tick && (count >= top);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Bundle the request and decode the configuration.
  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign cfg = '{sync_mode: tx_ctrl_q[sbrg_pkg::SBRG_BIT_SYNC_MODE],
                 high_speed: tx_ctrl_q[sbrg_pkg::SBRG_BIT_HIGH_SPEED],
                 wide: rate_ctrl_q[sbrg_pkg::SBRG_BIT_WIDE_DIVIDER],
                 clock_source: tx_ctrl_q[sbrg_pkg::SBRG_BIT_CLOCK_SOURCE],
                 enable: rx_ctrl_q[sbrg_pkg::SBRG_BIT_PORT_ENABLE]};
  assign mode = pick_mode(cfg); // RL3
  assign div_wr = req.wr && (req.addr == sbrg_pkg::SBRG_OFF_DIV_HIGH ||
                             req.addr == sbrg_pkg::SBRG_OFF_DIV_LOW);
  // Narrow divider ignores the high byte entirely.
  assign divisor = cfg.wide ? {div_high_q, div_low_q}
                            : {8'h00, div_low_q}; // RL1 RL16

  // Prescale top for the mode.
  always_comb begin
    case (mode)
      sbrg_pkg::SBRG_DIV64: pre_top = sbrg_pkg::SBRG_PRE_64;
      sbrg_pkg::SBRG_DIV16: pre_top = sbrg_pkg::SBRG_PRE_16;
      sbrg_pkg::SBRG_DIV4: pre_top = sbrg_pkg::SBRG_PRE_4;
      default: pre_top = 6'h00;
    endcase
  end

  // At-or-above rather than equal: a mode change without a divisor write
  // can leave the prescaler past the new top, and an equal compare would
  // then run it round all 64 counts before the next tick.
  assign pre_tick = (mode != sbrg_pkg::SBRG_STOP) && (pre_q >= pre_top);

  // Last prescale tick of a divider period.
  assign wrap = period_end(pre_tick, cnt_q, divisor); // RL2

  //////////////////////////////////////////////////////////////////////////
  // Control registers; read-only bits keep their reset values.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      tx_ctrl_q <= sbrg_pkg::SBRG_RST_TX_CTRL;
      rx_ctrl_q <= sbrg_pkg::SBRG_RST_RX_CTRL;
      rate_ctrl_q <= sbrg_pkg::SBRG_RST_RATE_CTRL; // RL1
    end else if (req.wr) begin
      case (req.addr)
        sbrg_pkg::SBRG_OFF_TX_CTRL: tx_ctrl_q <=
          (tx_ctrl_q & ~sbrg_pkg::SBRG_WMASK_TX_CTRL) |
          (req.wdata & sbrg_pkg::SBRG_WMASK_TX_CTRL);
        sbrg_pkg::SBRG_OFF_RX_CTRL: rx_ctrl_q <=
          (rx_ctrl_q & ~sbrg_pkg::SBRG_WMASK_RX_CTRL) |
          (req.wdata & sbrg_pkg::SBRG_WMASK_RX_CTRL);
        sbrg_pkg::SBRG_OFF_RATE_CTRL: rate_ctrl_q <=
          (rate_ctrl_q & ~sbrg_pkg::SBRG_WMASK_RATE_CTRL) |
          (req.wdata & sbrg_pkg::SBRG_WMASK_RATE_CTRL);
        default: ;
      endcase
    end
  end

  // Divisor pair. A zero divisor is left to software to avoid.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      div_high_q <= sbrg_pkg::SBRG_RST_DIV;
      div_low_q <= sbrg_pkg::SBRG_RST_DIV;
    end else if (req.wr && req.addr == sbrg_pkg::SBRG_OFF_DIV_HIGH) begin
      div_high_q <= req.wdata;
    end else if (req.wr && req.addr == sbrg_pkg::SBRG_OFF_DIV_LOW) begin
      div_low_q <= req.wdata;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        sbrg_pkg::SBRG_OFF_TX_CTRL: rdata_q <= tx_ctrl_q;
        sbrg_pkg::SBRG_OFF_RX_CTRL: rdata_q <= rx_ctrl_q;
        sbrg_pkg::SBRG_OFF_RATE_CTRL: rdata_q <= rate_ctrl_q;
        sbrg_pkg::SBRG_OFF_DIV_HIGH: rdata_q <= div_high_q;
        sbrg_pkg::SBRG_OFF_DIV_LOW: rdata_q <= div_low_q;
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Prescaler; cleared with the timer so a new rate starts clean.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || div_wr || mode == sbrg_pkg::SBRG_STOP) begin
      pre_q <= 6'h00; // RL8
    end else if (pre_tick) begin
      pre_q <= 6'h00;
    end else begin
      pre_q <= pre_q + 6'h01;
    end
  end

  // Free-running divider timer: counts n+1 prescale ticks per bit. A
  // stopped divider is held at zero, so enabling the port always starts
  // a full first period instead of finishing a stale one.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || div_wr || mode == sbrg_pkg::SBRG_STOP) begin
      cnt_q <= 16'h0000; // RL8 RL5
    end else if (wrap) begin
      cnt_q <= 16'h0000; // RL2
    end else if (pre_tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Bit tick and half-rate bit clock, both registered so that the pins
  // never carry decode glitches from the counter compare.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      tick_q <= 1'b0;
      bit_clk_q <= 1'b0;
    end else begin
      tick_q <= wrap; // RL2
      if (wrap) begin
        bit_clk_q <= ~bit_clk_q;
      end
    end
  end

  // Master flag: port drives its own clock only when sync master.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      master_q <= 1'b0;
    end else begin
      master_q <= cfg.enable && cfg.sync_mode && cfg.clock_source; // RL17
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive sampling: vote only in async unless both selects set.
  assign rx_sample = wrap;

  sbrg_sampler u_sampler (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .sample_in(rx_sample),
    .majority_in(!cfg.sync_mode &&
                 !(cfg.high_speed && cfg.wide)), // RL10 RL11
    .rx_pin_in(rx_pin_in),
    .rx_bit_out(rx_bit_out)
  );

  assign rdata_out = rdata_q;
  assign bit_tick_out = tick_q;
  assign bit_clk_out = bit_clk_q;
  assign master_out = master_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks. The rate checks look at the prescale top rather than at the
  // pin timing, so a wrong mode decode is caught in the first cycle that
  // it exists, long before a whole bit period has gone by.
  sequence s_div_write;
    div_wr;
  endsequence

  sequence s_timer_clear;
    cnt_q == 16'h0000 && pre_q == 6'h00;
  endsequence

  sequence s_timer_wrap;
    wrap && !div_wr;
  endsequence

  sequence s_tick_launched;
    tick_q && cnt_q == 16'h0000;
  endsequence

  // Timer restart and divisor pairing.
  a_div_write_clears: assert property (@(posedge sys_clk_in) // RL8
    disable iff (!rstn_in) s_div_write |=> s_timer_clear)
    else $error("divisor write did not clear the timer");

  a_narrow_ignores_high: assert property (@(posedge sys_clk_in) // RL16
    disable iff (!rstn_in) !cfg.wide |-> divisor[15:8] == 8'h00)
    else $error("high byte used in narrow mode");

  a_wide_uses_both: assert property (@(posedge sys_clk_in) // RL1
    disable iff (!rstn_in) cfg.wide |-> divisor == {div_high_q, div_low_q})
    else $error("wide divider lost a divisor byte");

  // Mode decode against the rate table.
  a_slave_no_tick: assert property (@(posedge sys_clk_in) // RL5
    disable iff (!rstn_in) (cfg.sync_mode && !cfg.clock_source) |->
      !pre_tick)
    else $error("slave mode produced a tick");

  a_disabled_no_tick: assert property (@(posedge sys_clk_in) // RL5
    disable iff (!rstn_in) !cfg.enable |-> !pre_tick)
    else $error("disabled port produced a tick");

  a_stop_holds_zero: assert property (@(posedge sys_clk_in) // RL5
    disable iff (!rstn_in) mode == sbrg_pkg::SBRG_STOP |=> s_timer_clear)
    else $error("stopped divider did not hold its counters at zero");

  a_slave_not_master: assert property (@(posedge sys_clk_in) // RL17
    disable iff (!rstn_in) (cfg.sync_mode && !cfg.clock_source) |=>
      !master_q)
    else $error("slave mode reported as master");

  a_sync_div_four: assert property (@(posedge sys_clk_in) // RL4
    disable iff (!rstn_in) (cfg.enable && cfg.sync_mode &&
      cfg.clock_source) |-> pre_top == sbrg_pkg::SBRG_PRE_4)
    else $error("sync prescale not four");

  a_async_div_sixty: assert property (@(posedge sys_clk_in) // RL6
    disable iff (!rstn_in) (cfg.enable && !cfg.sync_mode && !cfg.wide &&
      !cfg.high_speed) |-> pre_top == sbrg_pkg::SBRG_PRE_64)
    else $error("async low speed prescale not 64");

  a_async_div_sixteen: assert property (@(posedge sys_clk_in) // RL7 RL3
    disable iff (!rstn_in) (cfg.enable && !cfg.sync_mode &&
      (cfg.wide ^ cfg.high_speed)) |-> pre_top == sbrg_pkg::SBRG_PRE_16)
    else $error("async prescale not 16");

  a_async_fast_four: assert property (@(posedge sys_clk_in) // RL15
    disable iff (!rstn_in) (cfg.enable && !cfg.sync_mode && cfg.wide &&
      cfg.high_speed) |-> pre_top == sbrg_pkg::SBRG_PRE_4)
    else $error("async fast prescale not four");

  // Period end: tick, bit clock, and the narrow divider after reset.
  a_tick_follows_wrap: assert property (@(posedge sys_clk_in) // RL2
    disable iff (!rstn_in) s_timer_wrap |=> s_tick_launched)
    else $error("timer wrap without tick");

  a_clock_toggles: assert property (@(posedge sys_clk_in) // RL2
    disable iff (!rstn_in) s_timer_wrap |=> bit_clk_q != $past(bit_clk_q))
    else $error("bit clock did not toggle at the period end");

  a_reset_narrow: assert property (@(posedge sys_clk_in) // RL1
    $fell(rstn_in) |=> !cfg.wide)
    else $error("divider not narrow after reset");

endmodule // sbrg_top
`default_nettype wire

// ===== sbrg_top_bench.sv
// Self-checking testbench for the serial baud rate generator.
`timescale 1ns/10ps
`default_nettype none
module sbrg_top_bench;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic rx_pin_in = 1'b1;
  logic [7:0] rdata_out;
  logic bit_tick_out;
  logic bit_clk_out;
  logic rx_bit_out;
  logic master_out;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  sbrg_top dut (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .rx_pin_in(rx_pin_in),
    .bit_tick_out(bit_tick_out),
    .bit_clk_out(bit_clk_out),
    .rx_bit_out(rx_bit_out),
    .master_out(master_out)
  );

  // A 100 ns clock; the ceiling cuts a hang well past the longest period.
  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict, comparisons and register-port cycles.
  task automatic end_of_test();
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_per(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    chk_reg(rdata_out, exp);
  endtask

  // Counts edges up to and including the next tick, bounded.
  task automatic nxt(output int c);
    c = 0;
    do begin
      @(posedge sys_clk_in);
      #1;
      c++;
    end while (bit_tick_out !== 1'b1 && c < 9000);
  endtask

  task automatic cfg(input logic [7:0] tx, input logic [7:0] rate,
                     input logic [7:0] hi, input logic [7:0] lo);
    wr(sbrg_pkg::SBRG_OFF_RX_CTRL, 8'h80);
    wr(sbrg_pkg::SBRG_OFF_TX_CTRL, tx);
    wr(sbrg_pkg::SBRG_OFF_RATE_CTRL, rate);
    wr(sbrg_pkg::SBRG_OFF_DIV_HIGH, hi);
    wr(sbrg_pkg::SBRG_OFF_DIV_LOW, lo);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    rd(sbrg_pkg::SBRG_OFF_TX_CTRL, 8'h02);
    rd(sbrg_pkg::SBRG_OFF_RX_CTRL, 8'h00);
    rd(sbrg_pkg::SBRG_OFF_RATE_CTRL, 8'h40);
    rd(sbrg_pkg::SBRG_OFF_DIV_HIGH, 8'h00);
    rd(sbrg_pkg::SBRG_OFF_DIV_LOW, 8'h00);
    // Read-only bits keep their values; an unmapped place reads zero.
    wr(sbrg_pkg::SBRG_OFF_TX_CTRL, 8'h00);
    rd(sbrg_pkg::SBRG_OFF_TX_CTRL, 8'h02);
    wr(sbrg_pkg::SBRG_OFF_RX_CTRL, 8'hFF);
    rd(sbrg_pkg::SBRG_OFF_RX_CTRL, 8'hF9);
    wr(sbrg_pkg::SBRG_OFF_RATE_CTRL, 8'hFF);
    rd(sbrg_pkg::SBRG_OFF_RATE_CTRL, 8'hFB);
    wr(3'h5, 8'hA5);
    rd(3'h5, 8'h00);
    wr(sbrg_pkg::SBRG_OFF_DIV_HIGH, 8'h5A);
    rd(sbrg_pkg::SBRG_OFF_DIV_HIGH, 8'h5A);
  endtask

  // Measures the steady tick period for one setting.
  task automatic t_rate(input logic [7:0] tx, input logic [7:0] rate,
                        input logic [7:0] hi, input logic [7:0] lo,
                        input int exp, input logic mst);
    int c;
    cfg(tx, rate, hi, lo);
    nxt(c);
    nxt(c);
    chk_per(c, exp);
    chk_reg({7'h00, master_out}, {7'h00, mst});
  endtask

  // A slave or a disabled port must give no ticks at all.
  task automatic t_quiet(input logic [7:0] rx, input logic [7:0] tx);
    int n;
    n = 0;
    cfg(tx, 8'h00, 8'h00, 8'h01);
    wr(sbrg_pkg::SBRG_OFF_RX_CTRL, rx);
    repeat (300) begin
      @(posedge sys_clk_in);
      #1;
      if (bit_tick_out === 1'b1) n++;
    end
    chk_per(n, 0);
    chk_reg({7'h00, master_out}, 8'h00);
  endtask

  // Rewriting the divisor mid-period restarts the count from zero.
  task automatic t_restart();
    int c;
    cfg(8'h04, 8'h08, 8'h00, 8'h09);
    nxt(c);
    repeat (10) @(posedge sys_clk_in);
    wr(sbrg_pkg::SBRG_OFF_DIV_LOW, 8'h09);
    nxt(c);
    chk_per(c, 40);
  endtask

  // The sampled level follows a steady receive pin in both sampling modes;
  // the level is only taken at a bit tick, so each check waits for one.
  task automatic t_sample(input logic [7:0] tx, input logic [7:0] rate);
    int c;
    cfg(tx, rate, 8'h00, 8'h01);
    rx_pin_in <= 1'b0;
    nxt(c);
    chk_reg({7'h00, rx_bit_out}, 8'h00);
    rx_pin_in <= 1'b1;
    nxt(c);
    chk_reg({7'h00, rx_bit_out}, 8'h01);
  endtask

  // A reset in mid-run brings back the reset values and a narrow divider.
  task automatic t_reset();
    cfg(8'h04, 8'h08, 8'h01, 8'h02);
    @(posedge sys_clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    rd(sbrg_pkg::SBRG_OFF_TX_CTRL, 8'h02);
    rd(sbrg_pkg::SBRG_OFF_RX_CTRL, 8'h00);
    rd(sbrg_pkg::SBRG_OFF_RATE_CTRL, 8'h40);
    rd(sbrg_pkg::SBRG_OFF_DIV_HIGH, 8'h00);
    rd(sbrg_pkg::SBRG_OFF_DIV_LOW, 8'h00);
    chk_reg({7'h00, master_out}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    t_regs();
    t_rate(8'h00, 8'h00, 8'h00, 8'h02, 192, 1'b0);
    t_rate(8'h04, 8'h00, 8'h01, 8'h02, 48, 1'b0);
    t_rate(8'h00, 8'h08, 8'h01, 8'h02, 4144, 1'b0);
    t_rate(8'h04, 8'h08, 8'h00, 8'h05, 24, 1'b0);
    t_rate(8'h90, 8'h00, 8'h00, 8'h05, 24, 1'b1);
    t_rate(8'h94, 8'h00, 8'h00, 8'h05, 24, 1'b1);
    t_rate(8'h94, 8'h08, 8'h01, 8'h00, 1028, 1'b1);
    t_rate(8'h00, 8'h00, 8'h01, 8'h02, 192, 1'b0);
    t_quiet(8'h80, 8'h10);
    t_quiet(8'h00, 8'h00);
    t_restart();
    t_sample(8'h00, 8'h00);
    t_sample(8'h04, 8'h08);
    t_reset();
    end_of_test();
  end
endmodule // sbrg_top_bench
`default_nettype wire
